/* File: logic/dtc_pkg.sv */
package dtc_pkg;
    // Register indices; the byte address of each is four times its index.
    localparam logic [7:0]  IDX_PART_ID    = 8'h00;
    localparam logic [7:0]  IDX_DBNC_DELAY = 8'h18;
    localparam logic [7:0]  IDX_HDRM_CFG   = 8'h1b;
    localparam logic [7:0]  IDX_STATUS     = 8'h1c;
    localparam int          ADR_LSB        = 2;
    localparam int          ADR_MSB        = 9;

    // Field positions in the debounce delay register.
    localparam int          OV_SEL_LSB     = 0;
    localparam int          PHY_SEL_LSB    = 2;
    localparam int          WAKE_SEL_LSB   = 4;
    localparam int          DBNC_RSV_LSB   = 6;
    // Field positions in the headroom comparator register.
    localparam int          HDRM_SEL_LSB   = 0;
    localparam int          HDRM_THR_BIT   = 2;
    localparam int          HDRM_RSV_LSB   = 3;
    // Status register bits.
    localparam int          ST_OV_BIT      = 0;
    localparam int          ST_HDRM_BIT    = 1;
    localparam int          ST_WAKE_BIT    = 2;

    localparam logic [7:0]  DBNC_RESET     = 8'h00;
    localparam logic [7:0]  HDRM_RESET     = 8'h00;
    // Arbitrary neutral identity value.
    localparam logic [7:0]  PART_ID_VALUE  = 8'h5a;

    localparam int          CLK_PERIOD_NS  = 10;
    localparam int          CNT_W          = 24;

    // Qualification and wake-up times in nanoseconds.
    localparam int          T_10US_NS      = 10000;
    localparam int          T_100US_NS     = 100000;
    localparam int          T_1MS_NS       = 1000000;
    localparam int          T_10MS_NS      = 10000000;
    localparam int          T_8MS_NS       = 8000000;
    localparam int          T_16MS_NS      = 16000000;
    localparam int          T_32MS_NS      = 32000000;
    localparam int          T_100MS_NS     = 100000000;

    localparam int          CYC_10US       = T_10US_NS / CLK_PERIOD_NS;
    localparam int          CYC_100US      = T_100US_NS / CLK_PERIOD_NS;
    localparam int          CYC_1MS        = T_1MS_NS / CLK_PERIOD_NS;
    localparam int          CYC_10MS       = T_10MS_NS / CLK_PERIOD_NS;
    localparam int          CYC_8MS        = T_8MS_NS / CLK_PERIOD_NS;
    localparam int          CYC_16MS       = T_16MS_NS / CLK_PERIOD_NS;
    localparam int          CYC_32MS       = T_32MS_NS / CLK_PERIOD_NS;
    localparam int          CYC_100MS      = T_100MS_NS / CLK_PERIOD_NS;
endpackage

/* File: logic/dtc_qual.sv */
`timescale 1ns/10ps
module dtc_qual
    import dtc_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             event_i,
    input  wire logic [1:0]       sel_i,
    input  wire logic [CNT_W-1:0] lim0_i,
    input  wire logic [CNT_W-1:0] lim1_i,
    input  wire logic [CNT_W-1:0] lim2_i,
    input  wire logic [CNT_W-1:0] lim3_i,
    output logic                  qual_o
);
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] lim;
    logic             qual_q;

    always_comb begin
        case (sel_i)
            2'd0:    lim = lim0_i;
            2'd1:    lim = lim1_i;
            2'd2:    lim = lim2_i;
            default: lim = lim3_i;
        endcase
    end

    // Any drop of the event restarts the count from zero.
    always_ff @(posedge clk_i) begin
        if (rst_i || !event_i) begin
            cnt_q  <= '0;
            qual_q <= 1'b0;
        end else if (!qual_q) begin
            if (cnt_q >= lim - 1'b1) begin
                qual_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end

    assign qual_o = qual_q;

    AST_QUAL_AFTER_LIMIT: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(qual_q) |-> ($past(cnt_q) >= $past(lim) - 1'b1)
                          && $past(event_i))
        else $error("qualified before the selected time");
endmodule

/* File: logic/dtc_regs.sv */
// Our own choice: the Wishbone register port.
`timescale 1ns/10ps
// What this block does
// - Overvoltage debounce select picks 10us, 100us, 1ms or 10ms qualification.
// - Phy supply debounce field encodes 0, 16, 32 ms; stored only, no effect.
// - Wake-up delay field bits 5:4 picks 8, 16, 32 or 100 ms.
// - Headroom debounce select: code 0 reserved, then 100us, 1ms, 10ms.
// - Headroom threshold bit 2 picks 50 mV when clear, 175 mV when set.
// - Core logic reset returns every debounce, wake-up, threshold field to zero.
// - First reset class bits clear whenever the core digital supply is invalid.
// - Second reset class bits clear on power-on or processor reset.
// - Third reset class bits clear on a pulse into regulators-off mode.
// - Fuse-loaded fields take fuse defaults at load; software may overwrite.
module dtc_regs
    import dtc_pkg::*;
// Only the two base counts need setting; the other codes keep the fixed
// ratios between the selectable times, so a scaled run keeps the proportions.
#(
    parameter int unsigned CYC_OV0   = CYC_10US,
    parameter int unsigned CYC_OV1   = CYC_OV0 * (T_100US_NS / T_10US_NS),
    parameter int unsigned CYC_OV2   = CYC_OV0 * (T_1MS_NS / T_10US_NS),
    parameter int unsigned CYC_OV3   = CYC_OV0 * (T_10MS_NS / T_10US_NS),
    parameter int unsigned CYC_WAKE0 = CYC_8MS,
    parameter int unsigned CYC_WAKE1 = CYC_WAKE0 * (T_16MS_NS / T_8MS_NS),
    parameter int unsigned CYC_WAKE2 = CYC_WAKE0 * (T_32MS_NS / T_8MS_NS),
    parameter int unsigned CYC_WAKE3 = (CYC_WAKE0 * (T_100MS_NS / T_1MS_NS))
                                       / (T_8MS_NS / T_1MS_NS)
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [31:0] wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        core_logic_reset_n_i,
    input  wire logic        core_supply_valid_i,
    input  wire logic        power_on_reset_n_i,
    input  wire logic        processor_reset_n_i,
    input  wire logic        regs_off_toggle_i,
    input  wire logic        fuse_load_i,
    input  wire logic [5:0]  fuse_dbnc_i,
    input  wire logic [2:0]  fuse_hdrm_i,
    input  wire logic        ov_event_i,
    input  wire logic        headroom_event_i,
    input  wire logic        wakeup_request_i,
    output logic             ov_qualified_o,
    output logic             headroom_qualified_o,
    output logic             wakeup_ready_o,
    output logic             headroom_threshold_sel_o,
    output logic      [1:0]  phy_supply_debounce_sel_o
);
    import dtc_pkg::*;

    localparam logic [CNT_W-1:0] L_OV0   = CNT_W'(CYC_OV0);
    localparam logic [CNT_W-1:0] L_OV1   = CNT_W'(CYC_OV1);
    localparam logic [CNT_W-1:0] L_OV2   = CNT_W'(CYC_OV2);
    localparam logic [CNT_W-1:0] L_OV3   = CNT_W'(CYC_OV3);
    localparam logic [CNT_W-1:0] L_WAKE0 = CNT_W'(CYC_WAKE0);
    localparam logic [CNT_W-1:0] L_WAKE1 = CNT_W'(CYC_WAKE1);
    localparam logic [CNT_W-1:0] L_WAKE2 = CNT_W'(CYC_WAKE2);
    localparam logic [CNT_W-1:0] L_WAKE3 = CNT_W'(CYC_WAKE3);

    logic [7:0]  dbnc_q;
    logic [7:0]  hdrm_q;
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        req;
    logic        wr_lane0;
    logic        field_clr;
    logic        class2_clr;
    logic        class3_clr;
    logic        ov_qual;
    logic        hdrm_qual;
    logic        wake_qual;
    logic [1:0]  ov_sel;
    logic [1:0]  hdrm_sel;
    logic [1:0]  wake_sel;

    function automatic logic hit(input logic [31:0] adr,
                                 input logic [7:0]  idx);
        hit = (adr[ADR_MSB:ADR_LSB] == idx)
              && (adr[31:ADR_MSB+1] == '0)
              && (adr[ADR_LSB-1:0] == '0);
    endfunction

    assign req      = wb_cyc_i && wb_stb_i && !ack_q;
    assign wr_lane0 = req && wb_we_i && wb_sel_i[0];

    // The fields fall into the first class and also follow core logic reset.
    assign field_clr  = rst_i || !core_logic_reset_n_i
                        || !core_supply_valid_i;
    assign class2_clr = rst_i || !power_on_reset_n_i
                        || !processor_reset_n_i;
    assign class3_clr = rst_i || regs_off_toggle_i;

    assign ov_sel   = dbnc_q[OV_SEL_LSB +: 2];
    assign wake_sel = dbnc_q[WAKE_SEL_LSB +: 2];
    // Reserved code 0 of the headroom select behaves as the 100 us code so
    // that a comparator event can never qualify faster than documented.
    assign hdrm_sel = (hdrm_q[HDRM_SEL_LSB +: 2] == 2'd0) ? 2'd1
                      : hdrm_q[HDRM_SEL_LSB +: 2];

    always_ff @(posedge clk_i) begin
        if (field_clr) begin
            dbnc_q[5:0] <= DBNC_RESET[5:0];
        end else if (fuse_load_i) begin
            dbnc_q[5:0] <= fuse_dbnc_i;
        end else if (wr_lane0 && hit(wb_adr_i, IDX_DBNC_DELAY)) begin
            dbnc_q[5:0] <= wb_dat_i[5:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (class2_clr) begin
            dbnc_q[7:6] <= DBNC_RESET[7:6];
        end else if (wr_lane0 && hit(wb_adr_i, IDX_DBNC_DELAY)) begin
            dbnc_q[7:6] <= wb_dat_i[7:6];
        end
    end

    always_ff @(posedge clk_i) begin
        if (field_clr) begin
            hdrm_q[2:0] <= HDRM_RESET[2:0];
        end else if (fuse_load_i) begin
            hdrm_q[2:0] <= fuse_hdrm_i;
        end else if (wr_lane0 && hit(wb_adr_i, IDX_HDRM_CFG)) begin
            hdrm_q[2:0] <= wb_dat_i[2:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (class3_clr) begin
            hdrm_q[7:3] <= HDRM_RESET[7:3];
        end else if (wr_lane0 && hit(wb_adr_i, IDX_HDRM_CFG)) begin
            hdrm_q[7:3] <= wb_dat_i[7:3];
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        if (hit(wb_adr_i, IDX_PART_ID)) begin
            rdata_d[7:0] = PART_ID_VALUE;
        end else if (hit(wb_adr_i, IDX_DBNC_DELAY)) begin
            rdata_d[7:0] = dbnc_q;
        end else if (hit(wb_adr_i, IDX_HDRM_CFG)) begin
            rdata_d[7:0] = hdrm_q;
        end else if (hit(wb_adr_i, IDX_STATUS)) begin
            rdata_d[ST_OV_BIT]   = ov_qual;
            rdata_d[ST_HDRM_BIT] = hdrm_qual;
            rdata_d[ST_WAKE_BIT] = wake_qual;
        end
    end

    // One-cycle acknowledge; unmapped addresses are acknowledged with zero.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (req && !wb_we_i) begin
            rdata_q <= rdata_d;
        end
    end

    dtc_qual u_ov (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .event_i (ov_event_i),
        .sel_i   (ov_sel),
        .lim0_i  (L_OV0),
        .lim1_i  (L_OV1),
        .lim2_i  (L_OV2),
        .lim3_i  (L_OV3),
        .qual_o  (ov_qual)
    );

    dtc_qual u_hdrm (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .event_i (headroom_event_i),
        .sel_i   (hdrm_sel),
        .lim0_i  (L_OV1),
        .lim1_i  (L_OV1),
        .lim2_i  (L_OV2),
        .lim3_i  (L_OV3),
        .qual_o  (hdrm_qual)
    );

    dtc_qual u_wake (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .event_i (wakeup_request_i),
        .sel_i   (wake_sel),
        .lim0_i  (L_WAKE0),
        .lim1_i  (L_WAKE1),
        .lim2_i  (L_WAKE2),
        .lim3_i  (L_WAKE3),
        .qual_o  (wake_qual)
    );

    assign wb_ack_o                  = ack_q;
    assign wb_dat_o                  = rdata_q;
    assign ov_qualified_o            = ov_qual;
    assign headroom_qualified_o      = hdrm_qual;
    assign wakeup_ready_o            = wake_qual;
    // The threshold is a select for the analog comparator trim.
    assign headroom_threshold_sel_o  = hdrm_q[HDRM_THR_BIT];
    // The phy timer has no user here; the field is only passed out.
    assign phy_supply_debounce_sel_o = dbnc_q[PHY_SEL_LSB +: 2];

    sequence s_quiet;
        core_logic_reset_n_i && core_supply_valid_i && !fuse_load_i;
    endsequence

    sequence s_wr_hdrm;
        wr_lane0 && hit(wb_adr_i, IDX_HDRM_CFG) ##0 s_quiet;
    endsequence

    sequence s_wr_dbnc;
        wr_lane0 && hit(wb_adr_i, IDX_DBNC_DELAY) ##0 s_quiet;
    endsequence

    AST_CORE_RESET_CLEARS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !core_logic_reset_n_i |=> dbnc_q[5:0] == 6'h00
                                  && hdrm_q[2:0] == 3'h0)
        else $error("core reset left a field set");

    AST_SUPPLY_CLASS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !core_supply_valid_i |=> dbnc_q[5:0] == 6'h00
                                 && hdrm_q[2:0] == 3'h0)
        else $error("supply loss left a field set");

    AST_SEQ_END_CLASS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (!power_on_reset_n_i || !processor_reset_n_i)
        |=> dbnc_q[7:6] == 2'h0)
        else $error("second class bits not cleared");

    AST_REGS_OFF_CLASS: assert property (
        @(posedge clk_i) disable iff (rst_i)
        regs_off_toggle_i |=> hdrm_q[7:3] == 5'h00
                              && (hdrm_q[2:0] == $past(hdrm_q[2:0])
                                  || !$past(core_logic_reset_n_i)
                                  || $past(fuse_load_i)
                                  || !$past(core_supply_valid_i)
                                  || $past(wr_lane0)))
        else $error("third class bits not cleared");

    AST_FUSE_LOAD: assert property (
        @(posedge clk_i) disable iff (rst_i)
        fuse_load_i && core_logic_reset_n_i && core_supply_valid_i
        |=> dbnc_q[5:0] == $past(fuse_dbnc_i)
            && hdrm_q[2:0] == $past(fuse_hdrm_i))
        else $error("fuse defaults not loaded");

    AST_THRESHOLD_WRITE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_wr_hdrm |=> headroom_threshold_sel_o == $past(wb_dat_i[2]))
        else $error("threshold select did not follow write");

    AST_RESERVED_RW: assert property (
        @(posedge clk_i) disable iff (rst_i)
        s_wr_dbnc ##0 power_on_reset_n_i && processor_reset_n_i
        |=> dbnc_q == $past(wb_dat_i[7:0]))
        else $error("debounce register write lost");

    AST_ACK_PULSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("acknowledge not a single pulse");

    AST_OV_EVENT_DROP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !ov_event_i |=> !ov_qualified_o)
        else $error("overvoltage qualification kept after event drop");

    AST_HDRM_EVENT_DROP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !headroom_event_i |=> !headroom_qualified_o)
        else $error("headroom qualification kept after event drop");

    AST_WAKE_EVENT_DROP: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wakeup_request_i |=> !wakeup_ready_o)
        else $error("wake-up ready kept after request drop");

    AST_WAKE_CAUSE: assert property (
        @(posedge clk_i) disable iff (rst_i)
        $rose(wakeup_ready_o) |-> $past(wakeup_request_i, 1)
                                  && $past(wakeup_request_i, 2))
        else $error("wake-up ready without held request");
endmodule

/* File: dv/dtc_regs_tb_top.sv */
`timescale 1ns/10ps
`define CHK(nm, exp, got) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        bad_count++; \
        $display("MISMATCH %s exp %0h got %0h", nm, exp, got); \
    end \
end

module dtc_regs_tb_top;
    import dtc_pkg::*;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wb_cyc_i = 1'b0;
    logic        wb_stb_i = 1'b0;
    logic        wb_we_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0;
    logic [3:0]  wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic        wb_ack_o;
    logic        clr_n = 1'b1;
    logic        sup_ok = 1'b1;
    logic        por_n = 1'b1;
    logic        cpu_n = 1'b1;
    logic        off_tog = 1'b0;
    logic        fl = 1'b0;
    logic [5:0]  fd = 6'h0;
    logic [2:0]  fh = 3'h0;
    logic [2:0]  ev = 3'h0;
    logic        ovq, hdq, wkq, thr;
    logic [1:0]  phy;
    logic [7:0]  rd;
    int          bad_count = 0;
    int          tests_run = 0;
    int          cyc = 0;
    // Base counts shrunk; the other codes follow the fixed ratios of the
    // selectable times (10x steps for debounce, 8:16:32:100 for wake-up).
    int          ov_n[4] = '{4, 40, 400, 4000};
    int          hd_n[4] = '{40, 40, 400, 4000};
    int          wk_n[4] = '{8, 16, 32, 100};

    dtc_regs #(.CYC_OV0(4), .CYC_WAKE0(8))
    u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_logic_reset_n_i(clr_n),
        .core_supply_valid_i(sup_ok), .power_on_reset_n_i(por_n),
        .processor_reset_n_i(cpu_n), .regs_off_toggle_i(off_tog),
        .fuse_load_i(fl), .fuse_dbnc_i(fd), .fuse_hdrm_i(fh),
        .ov_event_i(ev[0]), .headroom_event_i(ev[1]),
        .wakeup_request_i(ev[2]), .ov_qualified_o(ovq),
        .headroom_qualified_o(hdq), .wakeup_ready_o(wkq),
        .headroom_threshold_sel_o(thr), .phy_supply_debounce_sel_o(phy));

    always #5 clk_i = ~clk_i;

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // The wait for ack is unbounded on purpose; only the cycle ceiling ends it.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 40000) begin
            bad_count++;
            close_out();
        end
    end

    task automatic wb_io(input logic we, input logic [7:0] idx,
                         input logic [7:0] wd, input logic [3:0] sel);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= {22'h0, idx, 2'b00};
        wb_sel_i <= sel;
        wb_dat_i <= {24'h0, wd};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        wb_io(1'b1, idx, d, 4'h1);
    endtask

    task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
        wb_io(1'b0, idx, 8'h00, 4'hf);
        `CHK("register", exp, rd)
    endtask

    task automatic t_rw();
        rd_chk(IDX_PART_ID, PART_ID_VALUE);
        rd_chk(IDX_DBNC_DELAY, DBNC_RESET);
        rd_chk(IDX_HDRM_CFG, HDRM_RESET);
        rd_chk(8'h33, 8'h00);
        wr(IDX_DBNC_DELAY, 8'hff);
        wr(IDX_HDRM_CFG, 8'hfc);
        wr(IDX_PART_ID, 8'h00);
        wb_io(1'b1, IDX_DBNC_DELAY, 8'h00, 4'h0);
        rd_chk(IDX_DBNC_DELAY, 8'hff);
        rd_chk(IDX_HDRM_CFG, 8'hfc);
        rd_chk(IDX_PART_ID, PART_ID_VALUE);
        `CHK("phy_sel", 2'b11, phy)
        `CHK("thr_sel", 1'b1, thr)
        wr(IDX_HDRM_CFG, 8'h00);
        #1 `CHK("thr_sel", 1'b0, thr)
    endtask

    task automatic t_fuse();
        wr(IDX_DBNC_DELAY, 8'hc0);
        wr(IDX_HDRM_CFG, 8'h08);
        @(posedge clk_i);
        fd <= 6'h2d;
        fh <= 3'h5;
        fl <= 1'b1;
        @(posedge clk_i);
        fl <= 1'b0;
        rd_chk(IDX_DBNC_DELAY, 8'hed);
        rd_chk(IDX_HDRM_CFG, 8'h0d);
        `CHK("thr_sel", 1'b1, thr)
        wr(IDX_DBNC_DELAY, 8'h12);
        rd_chk(IDX_DBNC_DELAY, 8'h12);
    endtask

    task automatic t_clears();
        for (int k = 0; k < 5; k++) begin
            wr(IDX_DBNC_DELAY, 8'hff);
            wr(IDX_HDRM_CFG, 8'hff);
            @(posedge clk_i);
            clr_n   <= (k != 0);
            sup_ok  <= (k != 1);
            por_n   <= (k != 2);
            cpu_n   <= (k != 3);
            off_tog <= (k == 4);
            @(posedge clk_i);
            clr_n   <= 1'b1;
            sup_ok  <= 1'b1;
            por_n   <= 1'b1;
            cpu_n   <= 1'b1;
            off_tog <= 1'b0;
            rd_chk(IDX_DBNC_DELAY, k < 2 ? 8'hc0 : k < 4 ? 8'h3f : 8'hff);
            rd_chk(IDX_HDRM_CFG, k < 2 ? 8'hf8 : k == 4 ? 8'h07 : 8'hff);
        end
    endtask

    function automatic logic q_of(input int w);
        return w == 0 ? ovq : w == 1 ? hdq : wkq;
    endfunction

    task automatic qual(input int w, input int n);
        @(posedge clk_i);
        ev[w] <= 1'b1;
        repeat (n - 2) @(posedge clk_i);
        #1 `CHK("qual_early", 1'b0, q_of(w))
        repeat (3) @(posedge clk_i);
        #1 `CHK("qual_late", 1'b1, q_of(w))
        rd_chk(IDX_STATUS, 8'h01 << w);
        @(posedge clk_i);
        ev[w] <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1 `CHK("qual_drop", 1'b0, q_of(w))
        @(posedge clk_i);
        ev[w] <= 1'b1;
        repeat (n - 2) @(posedge clk_i);
        ev[w] <= 1'b0;
        @(posedge clk_i);
        ev[w] <= 1'b1;
        repeat (n - 2) @(posedge clk_i);
        #1 `CHK("qual_restart", 1'b0, q_of(w))
        @(posedge clk_i);
        ev[w] <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask

    task automatic t_qual();
        for (int c = 0; c < 4; c++) begin
            wr(IDX_DBNC_DELAY, 8'(c));
            qual(0, ov_n[c]);
            wr(IDX_HDRM_CFG, 8'(c));
            qual(1, hd_n[c]);
            wr(IDX_DBNC_DELAY, 8'(c << 4));
            qual(2, wk_n[c]);
        end
    endtask

    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        t_rw();
        t_fuse();
        t_clears();
        t_qual();
        close_out();
    end
endmodule
